// ==== hw/hdci_pkg.sv ====
// hdci_pkg: shared constants, states and carrier structs for the disk controller
package hdci_pkg;
   // ==========================================================
   // task register file addresses
   localparam logic [2:0] REG_DATA = 3'h0;
   localparam logic [2:0] REG_ERR = 3'h1;
   localparam logic [2:0] REG_SECCNT = 3'h2;
   localparam logic [2:0] REG_SECNUM = 3'h3;
   localparam logic [2:0] REG_CYLLO = 3'h4;
   localparam logic [2:0] REG_CYLHI = 3'h5;
   localparam logic [2:0] REG_SDH = 3'h6;
   localparam logic [2:0] REG_CMD = 3'h7;
   // ==========================================================
   // status bit positions
   localparam int ST_BUSY = 7;
   localparam int ST_RDY = 6;
   localparam int ST_WF = 5;
   localparam int ST_SC = 4;
   localparam int ST_DRQ = 3;
   localparam int ST_CIP = 1;
   localparam int ST_ERR = 0;
   // error bit positions
   localparam int ER_ABORT = 2;
   localparam int ER_TK0 = 1;
   // ==========================================================
   // command classes, upper nibble of the command byte
   localparam logic [3:0] CMD_RESTORE = 4'h1;
   localparam logic [3:0] CMD_READ = 4'h2;
   localparam logic [3:0] CMD_WRITE = 4'h3;
   localparam logic [3:0] CMD_SEEK = 4'h7;
   // ==========================================================
   // timing
   localparam int CLK_MHZ = 125;
   localparam int STEP_NS = 1000;
   localparam int STEP_CYC = (STEP_NS * CLK_MHZ + 999) / 1000;
   localparam int CNT_W = 10;
   localparam logic [9:0] RESTORE_MAX = 10'h3FF;
   localparam logic [7:0] BYTE_ZERO = 8'h00;
   localparam logic [7:0] BYTE_ONES = 8'hFF;
   localparam logic [2:0] SYNC_ZERO = 3'h0;
   localparam logic [2:0] BIT_LAST = 3'h7;

   typedef enum {
      ST_IDLE, ST_CLR, ST_STEP, ST_SETTLE, ST_WAITBUF,
      ST_XFER, ST_DONE
   } hdci_state_t;

   // drive-side status pins grouped together
   typedef struct packed {
      logic ready;
      logic fault;
      logic track0;
      logic index;
      logic settled;
      logic run;
   } hdci_drive_t;

   // buffered data word on its way to the disk
   typedef struct packed {
      logic [7:0] data;
   } hdci_word_t;
endpackage : hdci_pkg

// ==== hw/hdci_top.sv ====
// hdci_top: host port, buffer control and drive side of the disk controller
module hdci_top #(
   parameter int BUF_DEPTH = 2
) (
   input wire logic sys_clk_i,
   input wire logic nrst_i,
   input wire logic chip_sel_n_i,
   input wire logic [2:0] register_select_i,
   input wire logic [7:0] host_byte_bus_i,
   output logic [7:0] host_byte_bus_o,
   output logic host_byte_bus_oe_o,
   input wire logic output_fetch_strobe_n_i,
   output logic output_fetch_strobe_n_o,
   output logic output_fetch_strobe_oe_o,
   input wire logic input_store_strobe_n_i,
   output logic input_store_strobe_n_o,
   output logic input_store_strobe_oe_o,
   output logic done_irq_o,
   output logic buffer_enable_n_o,
   input wire logic buffer_full_or_empty_i,
   output logic buffer_counter_clear_n_o,
   output logic buffer_transfer_request_o,
   input wire logic write_timing_clock_i,
   output logic mfm_out_o,
   output logic write_gate_out_o,
   output logic early_o,
   output logic late_o,
   input wire logic read_data_i,
   input wire logic recovered_clock_i,
   output logic read_gate_out_o,
   input wire logic pattern_run_detect_i,
   output logic step_o,
   output logic step_dir_o,
   input wire logic drive_ready_in_i,
   input wire logic drive_fault_in_i,
   input wire logic outer_track_in_i,
   input wire logic index_i,
   input wire logic head_settled_in_i,
   output logic low_current_out_o
);
   initial begin
      if (BUF_DEPTH != 2) $error("hdci_top: BUF_DEPTH must be 2");
   end

   // ==========================================================
   // pin synchronisers, async inputs pass two flops
   localparam int NSYNC = 11;
   logic [NSYNC-1:0] s1_q, s2_q, pin_w;
   assign pin_w = {chip_sel_n_i, output_fetch_strobe_n_i,
      input_store_strobe_n_i, buffer_full_or_empty_i, write_timing_clock_i,
      read_data_i, recovered_clock_i, pattern_run_detect_i,
      drive_ready_in_i, drive_fault_in_i, head_settled_in_i};
   logic [1:0] s1x_q, s2x_q;
   always_ff @(posedge sys_clk_i or negedge nrst_i) begin
      if (!nrst_i) begin
         s1_q <= '1;
         s2_q <= '1;
         s1x_q <= '0;
         s2x_q <= '0;
      end else begin
         s1_q <= pin_w;
         s2_q <= s1_q;
         s1x_q <= {outer_track_in_i, index_i};
         s2x_q <= s1x_q;
      end
   end
   logic cs_n, re_n, we_n, buffer_full_or_empty, wclk, rdat, rclk;
   hdci_pkg::hdci_drive_t drv;
   assign {cs_n, re_n, we_n, buffer_full_or_empty, wclk, rdat, rclk, drv.run, drv.ready,
      drv.fault, drv.settled} = s2_q;
   assign {drv.track0, drv.index} = s2x_q;

   // ==========================================================
   // host strobes, edges on sync'd levels
   logic re_d1_q, we_d1_q, wclk_d1_q, rclk_d1_q, idx_d1_q;
   always_ff @(posedge sys_clk_i or negedge nrst_i) begin
      if (!nrst_i) begin
         re_d1_q <= 1'b1;
         we_d1_q <= 1'b1;
         wclk_d1_q <= 1'b1;
         rclk_d1_q <= 1'b1;
         idx_d1_q <= 1'b0;
      end else begin
         re_d1_q <= re_n;
         we_d1_q <= we_n;
         wclk_d1_q <= wclk;
         rclk_d1_q <= rclk;
         idx_d1_q <= drv.index;
      end
   end
   logic dev_owns, host_wr, host_rd, wclk_rise, rclk_rise, idx_rise;
   // buffer phase: device owns strobes, host strobes ignored
   assign host_wr = !cs_n && !dev_owns && we_d1_q && !we_n;
   assign host_rd = !cs_n && !dev_owns && re_d1_q && !re_n;
   assign wclk_rise = wclk && !wclk_d1_q;
   assign rclk_rise = rclk && !rclk_d1_q;
   assign idx_rise = drv.index && !idx_d1_q;

   // ==========================================================
   // task register file
   logic [7:0] task_q [8];
   logic [7:0] err_q;
   hdci_pkg::hdci_state_t st_q;
   logic start_cmd;
   assign start_cmd = host_wr && register_select_i == hdci_pkg::REG_CMD
      && st_q == hdci_pkg::ST_IDLE;
   always_ff @(posedge sys_clk_i or negedge nrst_i) begin
      if (!nrst_i) begin
         for (int i = 0; i < 8; i++) task_q[i] <= hdci_pkg::BYTE_ZERO;
      end else if (host_wr) begin
         task_q[register_select_i] <= host_byte_bus_i;
      end
   end

   logic [7:0] status;
   logic busy;
   assign busy = st_q != hdci_pkg::ST_IDLE;
   always_comb begin
      status = hdci_pkg::BYTE_ZERO;
      status[hdci_pkg::ST_BUSY] = busy;
      status[hdci_pkg::ST_RDY] = drv.ready;
      status[hdci_pkg::ST_WF] = drv.fault;
      status[hdci_pkg::ST_SC] = drv.settled;
      status[hdci_pkg::ST_DRQ] = buffer_transfer_request_o;
      status[hdci_pkg::ST_CIP] = busy;
      status[hdci_pkg::ST_ERR] = |err_q;
   end

   always_ff @(posedge sys_clk_i or negedge nrst_i) begin
      if (!nrst_i) begin
         host_byte_bus_o <= hdci_pkg::BYTE_ZERO;
         host_byte_bus_oe_o <= 1'b0;
      end else begin
         host_byte_bus_oe_o <= !cs_n && !re_n && !dev_owns;
         if (host_rd) begin
            if (register_select_i == hdci_pkg::REG_CMD) begin
               host_byte_bus_o <= status;
            end else if (register_select_i == hdci_pkg::REG_ERR) begin
               host_byte_bus_o <= err_q;
            end else begin
               host_byte_bus_o <= task_q[register_select_i];
            end
         end
      end
   end

   // ==========================================================
   // two-entry buffer between sector buffer and serialiser
   hdci_pkg::hdci_word_t fifo_q [BUF_DEPTH];
   logic [1:0] fcnt_q;
   logic fwp_q, frp_q, in_valid, in_ready, out_valid, out_ready;
   assign in_ready = fcnt_q != 2'(BUF_DEPTH);
   assign out_valid = fcnt_q != 2'h0;
   logic push, pop;
   assign push = in_valid && in_ready;
   assign pop = out_valid && out_ready;
   always_ff @(posedge sys_clk_i or negedge nrst_i) begin
      if (!nrst_i) begin
         fcnt_q <= 2'h0;
         fwp_q <= 1'b0;
         frp_q <= 1'b0;
      end else begin
         if (push) fwp_q <= !fwp_q;
         if (pop) frp_q <= !frp_q;
         fcnt_q <= fcnt_q + 2'(push) - 2'(pop);
      end
   end
   always_ff @(posedge sys_clk_i) begin
      if (push) fifo_q[fwp_q].data <= host_byte_bus_i;
   end

   // ==========================================================
   // command sequencer
   logic [hdci_pkg::CNT_W-1:0] cnt_q;
   logic [7:0] step_tmr_q;
   logic is_wr, is_seek, is_rst;
   logic [3:0] op_q;
   assign is_wr = op_q == hdci_pkg::CMD_WRITE;
   assign is_rst = op_q == hdci_pkg::CMD_RESTORE;
   assign is_seek = is_rst || op_q == hdci_pkg::CMD_SEEK;
   logic [2:0] bit_q;
   logic ser_busy_q;
   // only the write phase drains the buffer
   assign out_ready = !ser_busy_q && st_q == hdci_pkg::ST_XFER && is_wr;
   assign dev_owns = !buffer_enable_n_o;
   assign in_valid = dev_owns && is_wr && !output_fetch_strobe_n_o;

   always_ff @(posedge sys_clk_i or negedge nrst_i) begin
      if (!nrst_i) begin
         st_q <= hdci_pkg::ST_IDLE;
         op_q <= 4'h0;
         err_q <= hdci_pkg::BYTE_ZERO;
         cnt_q <= '0;
         step_tmr_q <= 8'h00;
         done_irq_o <= 1'b0;
         buffer_counter_clear_n_o <= 1'b1;
         buffer_transfer_request_o <= 1'b0;
         buffer_enable_n_o <= 1'b1;
         step_o <= 1'b0;
         step_dir_o <= 1'b0;
         read_gate_out_o <= 1'b0;
         write_gate_out_o <= 1'b0;
      end else begin
         buffer_counter_clear_n_o <= 1'b1;
         if (host_rd && register_select_i == hdci_pkg::REG_CMD)
            done_irq_o <= 1'b0;
         if (step_tmr_q != 8'h00) step_tmr_q <= step_tmr_q - 8'h01;
         else step_o <= 1'b0;
         case (st_q)
            hdci_pkg::ST_IDLE: begin
               if (start_cmd) begin
                  op_q <= host_byte_bus_i[7:4];
                  err_q <= hdci_pkg::BYTE_ZERO;
                  cnt_q <= '0;
                  if (!drv.ready || drv.fault) begin
                     err_q[hdci_pkg::ER_ABORT] <= 1'b1;
                     st_q <= hdci_pkg::ST_DONE;
                  end else begin
                     st_q <= hdci_pkg::ST_CLR;
                  end
               end
            end
            hdci_pkg::ST_CLR: begin
               if (is_seek) begin
                  st_q <= hdci_pkg::ST_STEP;
               end else begin
                  buffer_counter_clear_n_o <= 1'b0;
                  buffer_transfer_request_o <= 1'b1;
                  st_q <= hdci_pkg::ST_WAITBUF;
               end
            end
            hdci_pkg::ST_STEP: begin
               step_dir_o <= !is_rst;
               if (is_rst && drv.track0) begin
                  st_q <= hdci_pkg::ST_SETTLE;
               end else if (is_rst && cnt_q == hdci_pkg::RESTORE_MAX) begin
                  err_q[hdci_pkg::ER_TK0] <= 1'b1;
                  st_q <= hdci_pkg::ST_DONE;
               end else if (!is_rst && cnt_q[7:0] ==
                     task_q[hdci_pkg::REG_CYLLO]) begin
                  st_q <= hdci_pkg::ST_SETTLE;
               end else if (step_tmr_q == 8'h00 && !step_o) begin
                  step_o <= 1'b1;
                  step_tmr_q <= 8'(hdci_pkg::STEP_CYC - 1);
                  cnt_q <= cnt_q + 10'h001;
               end
            end
            hdci_pkg::ST_SETTLE: begin
               if (drv.settled) st_q <= hdci_pkg::ST_DONE;
            end
            hdci_pkg::ST_WAITBUF: begin
               if (buffer_full_or_empty) begin
                  buffer_transfer_request_o <= 1'b0;
                  buffer_enable_n_o <= 1'b0;
                  buffer_counter_clear_n_o <= 1'b0;
                  read_gate_out_o <= !is_wr;
                  write_gate_out_o <= is_wr;
                  cnt_q <= '0;
                  st_q <= hdci_pkg::ST_XFER;
               end
            end
            hdci_pkg::ST_XFER: begin
               if (!buffer_full_or_empty) cnt_q[0] <= 1'b1;
               if (!drv.ready || drv.fault) begin
                  err_q[hdci_pkg::ER_ABORT] <= 1'b1;
                  st_q <= hdci_pkg::ST_DONE;
               end else if (!is_wr && drv.run && idx_rise) begin
                  st_q <= hdci_pkg::ST_DONE;
               end else if (is_wr && buffer_full_or_empty && cnt_q[0] && !out_valid
                     && !ser_busy_q) begin
                  st_q <= hdci_pkg::ST_DONE; // buffer empty, all sent
               end
            end
            hdci_pkg::ST_DONE: begin
               buffer_enable_n_o <= 1'b1;
               read_gate_out_o <= 1'b0;
               write_gate_out_o <= 1'b0;
               buffer_transfer_request_o <= 1'b0;
               done_irq_o <= 1'b1;
               st_q <= hdci_pkg::ST_IDLE;
            end
            default: st_q <= hdci_pkg::ST_IDLE;
         endcase
      end
   end

   // ==========================================================
   // device-driven buffer strobes, at most one fetch low per write clock on writes, one store low per read clock on reads
   logic own_d;
   assign own_d = st_q != hdci_pkg::ST_DONE && (dev_owns
      || st_q == hdci_pkg::ST_WAITBUF && buffer_full_or_empty);
   always_ff @(posedge sys_clk_i or negedge nrst_i) begin
      if (!nrst_i) begin
         output_fetch_strobe_n_o <= 1'b1;
         output_fetch_strobe_oe_o <= 1'b0;
         input_store_strobe_n_o <= 1'b1;
         input_store_strobe_oe_o <= 1'b0;
      end else begin
         output_fetch_strobe_oe_o <= own_d;
         input_store_strobe_oe_o <= own_d;
         // fetch while the fifo has room, stop once the buffer is empty
         output_fetch_strobe_n_o <= !(dev_owns && is_wr && in_ready &&
            wclk_rise && !(buffer_full_or_empty && cnt_q[0]));
         input_store_strobe_n_o <= !(dev_owns && !is_wr && rclk_rise);
      end
   end

   // ==========================================================
   // MFM serialiser with precompensation on write clock
   logic [7:0] sh_q;
   logic prev_q, half_q;
   always_ff @(posedge sys_clk_i or negedge nrst_i) begin
      if (!nrst_i) begin
         sh_q <= hdci_pkg::BYTE_ZERO;
         bit_q <= hdci_pkg::SYNC_ZERO;
         ser_busy_q <= 1'b0;
         prev_q <= 1'b0;
         half_q <= 1'b0;
         mfm_out_o <= 1'b0;
         early_o <= 1'b0;
         late_o <= 1'b0;
         low_current_out_o <= 1'b0;
      end else begin
         low_current_out_o <= write_gate_out_o && task_q[hdci_pkg::REG_CYLLO]
            >= task_q[hdci_pkg::REG_ERR];
         if (pop) begin
            sh_q <= fifo_q[frp_q].data;
            bit_q <= hdci_pkg::SYNC_ZERO;
            half_q <= 1'b0;
            ser_busy_q <= 1'b1;
         end else if (ser_busy_q && wclk_rise) begin
            half_q <= !half_q;
            if (!half_q) begin
               // clock cell: pulse only between two zeroes
               mfm_out_o <= !prev_q && !sh_q[7];
            end else begin
               mfm_out_o <= sh_q[7];
               early_o <= sh_q[7] && !prev_q && sh_q[6];
               late_o <= sh_q[7] && prev_q && !sh_q[6];
               prev_q <= sh_q[7];
               sh_q <= {sh_q[6:0], 1'b0};
               bit_q <= bit_q + 3'h1;
               if (bit_q == hdci_pkg::BIT_LAST) ser_busy_q <= 1'b0;
            end
         end else if (!ser_busy_q) begin
            mfm_out_o <= 1'b0;
            early_o <= 1'b0;
            late_o <= 1'b0;
         end
      end
   end
endmodule : hdci_top

// ==== test/hdci_checker.sv ====
// hdci_checker: port-level assertions for the disk controller top
module hdci_checker (
   input wire logic sys_clk_i,
   input wire logic nrst_i,
   input wire logic chip_sel_n_i,
   input wire logic host_byte_bus_oe_o,
   input wire logic output_fetch_strobe_oe_o,
   input wire logic input_store_strobe_oe_o,
   input wire logic done_irq_o,
   input wire logic buffer_enable_n_o,
   input wire logic buffer_counter_clear_n_o,
   input wire logic mfm_out_o,
   input wire logic write_gate_out_o,
   input wire logic step_o,
   input wire logic step_dir_o
);
   timeunit 1ns;
   timeprecision 100ps;
   default clocking cb @(posedge sys_clk_i);
   endclocking
   default disable iff (!nrst_i);
   // ==========================================================
   // step width in cycles
   logic [9:0] step_len_q;
   always_ff @(posedge sys_clk_i or negedge nrst_i) begin
      if (!nrst_i) step_len_q <= 10'h000;
      else step_len_q <= step_o ? step_len_q + 10'h001 : 10'h000;
   end
   // ==========================================================
   // buffer and host side
   property p_clr_pulse;
      !buffer_counter_clear_n_o |=> buffer_counter_clear_n_o;
   endproperty
   a_clr_pulse: assert property (p_clr_pulse)
      else $error("counter clear low for more than one cycle");
   property p_clr_first;
      $fell(buffer_enable_n_o) |-> !buffer_counter_clear_n_o
         || !$past(buffer_counter_clear_n_o)
         || !$past(buffer_counter_clear_n_o, 2);
   endproperty
   a_clr_first: assert property (p_clr_first)
      else $error("buffer enabled without a counter clear");
   property p_strobe_own;
      !buffer_enable_n_o |-> output_fetch_strobe_oe_o
         && input_store_strobe_oe_o;
   endproperty
   a_strobe_own: assert property (p_strobe_own)
      else $error("strobes not driven while buffer owned");
   property p_bus_free;
      host_byte_bus_oe_o |-> buffer_enable_n_o;
   endproperty
   a_bus_free: assert property (p_bus_free)
      else $error("host bus driven while buffer owned");
   property p_irq_hold;
      done_irq_o && chip_sel_n_i && $past(chip_sel_n_i, 3) |=> done_irq_o;
   endproperty
   a_irq_hold: assert property (p_irq_hold)
      else $error("interrupt dropped without a status read");
   // ==========================================================
   // drive side
   property p_step_len;
      $fell(step_o) |-> step_len_q == 10'(hdci_pkg::STEP_CYC);
   endproperty
   a_step_len: assert property (p_step_len)
      else $error("step pulse width wrong");
   property p_dir_hold;
      step_o && $past(step_o) |-> $stable(step_dir_o);
   endproperty
   a_dir_hold: assert property (p_dir_hold)
      else $error("direction moved during a step pulse");
   property p_wd_gated;
      $rose(mfm_out_o) |-> write_gate_out_o;
   endproperty
   a_wd_gated: assert property (p_wd_gated)
      else $error("write pulse without write gate");
endmodule : hdci_checker

bind hdci_top hdci_checker u_checker (
   .sys_clk_i(sys_clk_i), .nrst_i(nrst_i), .chip_sel_n_i(chip_sel_n_i),
   .host_byte_bus_oe_o(host_byte_bus_oe_o),
   .output_fetch_strobe_oe_o(output_fetch_strobe_oe_o),
   .input_store_strobe_oe_o(input_store_strobe_oe_o),
   .done_irq_o(done_irq_o), .buffer_enable_n_o(buffer_enable_n_o),
   .buffer_counter_clear_n_o(buffer_counter_clear_n_o),
   .mfm_out_o(mfm_out_o), .write_gate_out_o(write_gate_out_o),
   .step_o(step_o), .step_dir_o(step_dir_o)
);

// ==== test/hdci_drive_model.sv ====
// hdci_drive_model: disk drive and sector buffer facing the controller
module hdci_drive_model (
   input wire logic sys_clk_i,
   input wire logic nrst_i,
   input wire logic [3:0] start_cyl_i,
   input wire logic [3:0] lat_i,
   input wire logic ready_i,
   input wire logic fault_i,
   input wire logic step_i,
   input wire logic dir_i,
   input wire logic rg_i,
   input wire logic req_i,
   input wire logic en_n_i,
   input wire logic strobe_n_i,
   output logic wclk_o,
   output logic rclk_o,
   output logic rdata_o,
   output logic ready_o,
   output hdci_pkg::hdci_drive_t drive_o
);
   timeunit 1ns;
   timeprecision 100ps;
   logic [3:0] cyl_q, wait_q;
   logic [2:0] bytes_q;
   logic [6:0] settle_q;
   logic [5:0] run_q;
   logic [10:0] rev_q;
   logic step_q, req_q, en_q, stb_q;
   // ==========================================================
   // link clocks run free, read clock offset so phases never align
   initial {wclk_o, rclk_o, rdata_o} = 3'h0;
   always #40 wclk_o = ~wclk_o;
   initial begin
      #13;
      forever #40 rclk_o = ~rclk_o;
   end
   always @(posedge rclk_o) rdata_o <= ~rdata_o;
   // ==========================================================
   // head, settling, run detector, index
   always_ff @(posedge sys_clk_i or negedge nrst_i) begin
      if (!nrst_i) begin
         cyl_q <= start_cyl_i;
         settle_q <= 7'h00;
         run_q <= 6'h00;
         rev_q <= 11'h000;
         {step_q, req_q, en_q, stb_q} <= 4'h3;
      end else begin
         {step_q, req_q, en_q, stb_q} <= {step_i, req_i, en_n_i, strobe_n_i};
         rev_q <= rev_q + 11'h001;
         if (step_i && !step_q) cyl_q <= dir_i ? cyl_q + 4'h1 : cyl_q - 4'h1;
         settle_q <= step_i ? 7'h40 : settle_q - {6'h00, settle_q != 7'h00};
         run_q <= !rg_i ? 6'h00 : run_q + {5'h00, run_q != 6'h3F};
      end
   end
   // ==========================================================
   // sector buffer: ready after lat_i cycles or 4 bytes
   always_ff @(posedge sys_clk_i or negedge nrst_i) begin
      if (!nrst_i) begin
         ready_o <= 1'b0;
         wait_q <= 4'h0;
         bytes_q <= 3'h0;
      end else if (req_i && !req_q) begin
         ready_o <= 1'b0;
         wait_q <= lat_i;
      end else if (wait_q != 4'h0) begin
         wait_q <= wait_q - 4'h1;
         ready_o <= wait_q == 4'h1;
      end else if (en_n_i != en_q) begin
         ready_o <= 1'b0;
         bytes_q <= 3'h0;
      end else if (!en_n_i && !strobe_n_i && stb_q) begin
         bytes_q <= bytes_q + 3'h1;
         ready_o <= ready_o || bytes_q == 3'h3;
      end
   end
   always_comb begin
      drive_o.ready = ready_i;
      drive_o.fault = fault_i;
      drive_o.track0 = cyl_q == 4'h0;
      drive_o.index = rev_q < 11'h010;
      drive_o.settled = settle_q == 7'h00;
      drive_o.run = run_q == 6'h3F;
   end
endmodule : hdci_drive_model

// ==== test/hdci_top_test.sv ====
// hdci_top_test: self-checking bench for the disk controller top
module hdci_top_test;
   timeunit 1ns;
   timeprecision 100ps;
   logic clk, nrst, cs_n, h_drv, h_re_n, h_we_n, rdy_pin, flt_pin, oe_q;
   logic [2:0] sel;
   logic [7:0] h_d, bus_i, bus_o, q, st, er;
   logic [3:0] start_cyl, lat, tgt;
   logic bus_oe, re_o, re_oe, we_o, we_oe, re_i, we_i, irq, en_n, clr_n;
   logic req, mfm, wg, rg, step, dir, wclk, rclk, rdat, buffer_full_or_empty;
   logic p_clr, p_en, p_req, p_wg, p_rg, p_mfm, p_step;
   logic [31:0] seed;
   hdci_pkg::hdci_drive_t drv;
   int miscompares, checks_done, cyc;
   int n_clr, n_en, n_req, n_wg, n_rg, n_mfm, n_in, n_out;
   assign re_i = re_oe ? re_o : h_re_n;
   assign we_i = we_oe ? we_o : h_we_n;
   // undriven bus shows a moving pattern, never a stale byte
   assign bus_i = h_drv ? h_d : (!en_n && !re_i) ? {cyc[4:0], 3'h5}
      : ~cyc[7:0];
   hdci_top u_dut (
      .sys_clk_i(clk), .nrst_i(nrst), .chip_sel_n_i(cs_n),
      .register_select_i(sel), .host_byte_bus_i(bus_i),
      .host_byte_bus_o(bus_o), .host_byte_bus_oe_o(bus_oe),
      .output_fetch_strobe_n_i(re_i), .output_fetch_strobe_n_o(re_o),
      .output_fetch_strobe_oe_o(re_oe), .input_store_strobe_n_i(we_i),
      .input_store_strobe_n_o(we_o), .input_store_strobe_oe_o(we_oe),
      .done_irq_o(irq), .buffer_enable_n_o(en_n),
      .buffer_full_or_empty_i(buffer_full_or_empty), .buffer_counter_clear_n_o(clr_n),
      .buffer_transfer_request_o(req), .write_timing_clock_i(wclk),
      .mfm_out_o(mfm), .write_gate_out_o(wg), .early_o(), .late_o(),
      .read_data_i(rdat), .recovered_clock_i(rclk),
      .read_gate_out_o(rg), .pattern_run_detect_i(drv.run),
      .step_o(step), .step_dir_o(dir), .drive_ready_in_i(drv.ready),
      .drive_fault_in_i(drv.fault), .outer_track_in_i(drv.track0),
      .index_i(drv.index), .head_settled_in_i(drv.settled),
      .low_current_out_o()
   );
   hdci_drive_model u_drive (
      .sys_clk_i(clk), .nrst_i(nrst), .start_cyl_i(start_cyl),
      .lat_i(lat), .ready_i(rdy_pin), .fault_i(flt_pin), .step_i(step),
      .dir_i(dir), .rg_i(rg), .req_i(req), .en_n_i(en_n),
      .strobe_n_i(re_i && we_i), .wclk_o(wclk), .rclk_o(rclk),
      .rdata_o(rdat), .ready_o(buffer_full_or_empty), .drive_o(drv)
   );
   always #4 clk = ~clk;
   // ==========================================================
   // expectations
   function automatic logic [31:0] lfsr(input logic [31:0] x);
      return {x[30:0], x[31] ^ x[21] ^ x[1] ^ x[0]};
   endfunction : lfsr
   function automatic int steps(input int from, input int to);
      return from > to ? from - to : to - from;
   endfunction : steps
   task automatic report_and_stop;
      $display("checks %0d, mismatches %0d", checks_done, miscompares);
      if (miscompares == 0 && checks_done > 0) begin
         $display("SIMULATION PASSED");
      end else begin
         $display("SIMULATION FAILED");
      end
      $finish;
   endtask : report_and_stop
   task automatic chk(input logic ok, input string msg);
      checks_done++;
      if (ok !== 1'b1) begin
         miscompares++;
         $display("mismatch at %0t: %s", $time, msg);
      end
   endtask : chk
   // ==========================================================
   // edge counters and timeout
   always @(posedge clk) begin
      cyc <= cyc + 1;
      if (!clr_n && p_clr) n_clr++;
      if (!en_n && p_en) n_en++;
      if (req && !p_req) n_req++;
      if (wg && !p_wg) n_wg++;
      if (rg && !p_rg) n_rg++;
      if (mfm && !p_mfm) n_mfm++;
      if (step && !p_step && dir) n_in++;
      if (step && !p_step && !dir) n_out++;
      {p_clr, p_en, p_req, p_wg, p_rg, p_mfm, p_step} <=
         {clr_n, en_n, req, wg, rg, mfm, step};
      if (cyc == 60000) begin
         miscompares++;
         report_and_stop();
      end
   end
   // ==========================================================
   // host port: strobe held past the sync
   task automatic host_cyc(input logic sel_n, input logic wr,
      input logic [2:0] a, input logic [7:0] d);
      @(posedge clk);
      #1;
      cs_n = sel_n;
      sel = a;
      h_d = d;
      h_drv = wr;
      h_we_n = !wr;
      h_re_n = wr;
      repeat (5) @(posedge clk);
      q = bus_o;
      oe_q = bus_oe;
      #1;
      h_we_n = 1'b1;
      h_re_n = 1'b1;
      h_drv = 1'b0;
      @(posedge clk);
      #1;
      cs_n = 1'b1;
      repeat (3) @(posedge clk);
   endtask : host_cyc
   task automatic run_cmd(input logic [3:0] cls);
      int k = 0;
      @(posedge clk);
      #1;
      {n_clr, n_en, n_req, n_wg, n_rg, n_mfm, n_in, n_out} = 256'h0;
      host_cyc(1'b0, 1'b1, hdci_pkg::REG_CMD, {cls, 4'h0});
      while (irq !== 1'b1 && k < 20000) begin
         @(posedge clk);
         k++;
      end
      chk(irq === 1'b1, "no completion interrupt");
      host_cyc(1'b0, 1'b0, hdci_pkg::REG_ERR, 8'h00);
      er = q;
      host_cyc(1'b0, 1'b0, hdci_pkg::REG_CMD, 8'h00);
      st = q;
      chk(oe_q === 1'b1 && irq === 1'b0, "status read kept irq");
   endtask : run_cmd
   // ==========================================================
   // main sequence
   initial begin
      // reset low, bus idle, drive ready
      {clk, nrst, cs_n, h_drv, h_re_n, h_we_n, rdy_pin, flt_pin} = 8'h2E;
      sel = 3'h0;
      h_d = 8'h00;
      {miscompares, checks_done, cyc, n_out} = 128'h0;
      seed = lfsr(32'h2B09);
      start_cyl = {1'b0, seed[2:0]} + 4'h1;
      tgt = {1'b0, seed[6:4]} + 4'h1;
      lat = 4'h1;
      repeat (20) @(posedge clk);
      #1;
      nrst = 1'b1;
      repeat (4) @(posedge clk);
      #1;
      chk(irq === 1'b0 && en_n === 1'b1 && clr_n === 1'b1 && req === 1'b0
         && step === 1'b0 && wg === 1'b0 && rg === 1'b0, "reset");
      host_cyc(1'b1, 1'b0, hdci_pkg::REG_CMD, 8'h00);
      chk(oe_q === 1'b0, "bus driven while deselected");
      host_cyc(1'b1, 1'b1, hdci_pkg::REG_CMD, {hdci_pkg::CMD_RESTORE, 4'h0});
      repeat (200) @(posedge clk);
      chk(n_out == 0 && irq === 1'b0, "deselected command ran");
      run_cmd(hdci_pkg::CMD_RESTORE);
      chk(n_out == steps(start_cyl, 0) && n_in == 0, "restore");
      chk(er === 8'h00 && st[hdci_pkg::ST_BUSY] === 1'b0
         && st[hdci_pkg::ST_RDY] === 1'b1, "restore status");
      host_cyc(1'b0, 1'b1, hdci_pkg::REG_CYLLO, {4'h0, tgt});
      host_cyc(1'b0, 1'b0, hdci_pkg::REG_CYLLO, 8'h00);
      chk(q === {4'h0, tgt}, "cylinder readback");
      run_cmd(hdci_pkg::CMD_SEEK);
      chk(n_in == steps(0, tgt) && n_out == 0, "seek steps");
      for (int i = 0; i < 4; i++) begin
         seed = lfsr(seed);
         // later buffers stall
         lat = (i < 2) ? 4'h1 : (seed[3:0] | 4'h8);
         run_cmd(i[0] ? hdci_pkg::CMD_READ : hdci_pkg::CMD_WRITE);
         chk(n_clr == 2 && n_req == 1 && n_en == 1, "buffer");
         chk(er === 8'h00, "transfer error");
         chk(i[0] ? (n_rg == 1 && n_wg == 0)
            : (n_wg == 1 && n_mfm > 0 && n_rg == 0), "gates");
      end
      for (int k = 0; k < 2; k++) begin
         #1;
         rdy_pin = k[0];
         flt_pin = k[0];
         run_cmd(hdci_pkg::CMD_READ);
         chk(er[hdci_pkg::ER_ABORT] === 1'b1 && n_rg == 0, "abort");
      end
      report_and_stop();
   end
endmodule : hdci_top_test
